// file: logic/serdes_tx_pkg.sv
// Package with register map, field layout, reset values and idle test table for the lane transmit register bank.
`default_nettype none
package serdes_tx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices as printed; the byte address is four times the index.
  localparam logic [7:0] IDX_TX_ANALOG_SETTINGS = 8'h20;
  localparam logic [7:0] IDX_LANE_CONTROL_TWO = 8'h22;
  localparam logic [7:0] IDX_SWING_OVR_CTRL = 8'h30;
  localparam logic [7:0] IDX_IDLE_STAGE_PATCH = 8'h3C;
  localparam int ADDR_W = 12;
  localparam int BYTE_SHIFT = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int SWING_HI = 15;
  localparam int SWING_LO = 12;
  localparam int SWING_AUTO_BIT = 14;
  localparam int ANA_RSVD_HI = 11;
  localparam int ANA_RSVD_LO = 9;
  localparam int PREEMPH_HI = 8;
  localparam int PREEMPH_LO = 6;
  localparam int ANA_LOW_HI = 5;
  localparam int WIPE_BIT = 14;
  localparam int IDLE_TEST_BIT = 13;
  localparam int SEND_FORCE_BIT = 5;
  localparam int SWING_OVR_BIT = 12;
  localparam int PATCH_EN_BIT = 15;
  localparam int PATCH_HI = 9;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [3:0] SWING_RST = 4'hC;
  localparam logic [2:0] ANA_RSVD_VAL = 3'h4;
  localparam logic [2:0] PREEMPH_RST = 3'h0;
  localparam logic [5:0] ANA_LOW_RST = 6'h20;
  localparam logic [9:0] PATCH_RST = 10'h289;

  ////////////////////////////////////////////////////////////////////////////
  // Idle test sequence: sixteen 10-bit codes, stage 0 in the low bits.
  localparam int IDLE_STAGES = 16;
  localparam int CODE_W = 10;
  localparam int PATCH_STAGE = 6;
  // Even stages carry 289h so that stage 6 holds the default code that the patch replaces.
  localparam logic [159:0] IDLE_TABLE = {
    10'h0FA, 10'h289, 10'h0FA, 10'h289, 10'h0FA, 10'h289, 10'h0FA, 10'h289,
    10'h0FA, 10'h289, 10'h0FA, 10'h289, 10'h0FA, 10'h289, 10'h0FA, 10'h289
  };

  ////////////////////////////////////////////////////////////////////////////
  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// file: logic/serdes_tx_regs.sv
// Transmit amplitude, pre-emphasis and test control registers of one lane, behind an AXI4-Lite slave.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// (RL1) With override set, swing field 15:12 picks one of 16 levels; resets to 1100. Here bit 14 stays 1, so only 8 levels are reachable.
// (RL2) With override clear, swing bit 14 follows lane mode, SGMII or fibre.
// (RL3) Software writes swing bits 15, 13, 12 only; all four bits drive amplitude.
// (RL4) Pre-emphasis field 8:6 resets to zero; 0 none, 7 half, roughly linear.
// (RL5) Writing one to control-two bit 14 wipes the error count; bit self-clears.
// (RL6) While control-two bit 13 is set, send the 16-stage idle test codes.
// (RL7) Patch value bits 9:0 replace the default stage 6 code 289h.
// (RL8) Patch settings together with the idle test bit change the sent sequence.
// (RL9) While control-two bit 5 is set, packets go out without link or sync.
// (RL10) Software writes zero to reserved control-two bits and ignores their reads.
// (RL11) Override control bit 12 gives software full control of the swing field; here bit 14 stays unwritable, held at its reset value 1.
// (RL12) Stages go out in order, repeat gaplessly, restart at zero on new set.
module serdes_tx_regs #(
  parameter int SWING_W = 4,
  parameter int PREEMPH_W = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic lane_is_fiber,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [SWING_W-1:0] tx_swing_level,
  output logic [PREEMPH_W-1:0] tx_preemph_coeff,
  output logic bit_error_count_wipe,
  output logic send_despite_no_link,
  output logic idle_test_active,
  output logic [9:0] idle_test_code
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage.
  logic swing_b15_q;
  logic swing_b14_q;
  logic swing_b13_q;
  logic swing_b12_q;
  logic [PREEMPH_W-1:0] preemph_q;
  logic [5:0] ana_low_q;
  logic tx_swing_override_q;
  logic idle_test_q;
  logic idle_test_prev_q;
  logic send_force_q;
  logic patch_en_q;
  logic [9:0] patch_code_q;
  logic [3:0] stage_q;
  logic [3:0] swing_eff;
  logic [15:0] analog_rd;
  logic [15:0] ctrl2_rd;

  // Write path decode.
  logic wr_fire;
  logic [serdes_tx_pkg::ADDR_W-serdes_tx_pkg::BYTE_SHIFT-1:0] wr_idx;
  logic [serdes_tx_pkg::ADDR_W-serdes_tx_pkg::BYTE_SHIFT-1:0] rd_idx;
  logic wr_lo;
  logic wr_hi;
  logic wr_is_analog;
  logic wr_is_ctrl2;
  logic wr_is_ovr;
  logic wr_is_patch;

  // Prot, high data and strobe bits and the low address bits are not used by this slave.
  logic unused_ok;
  assign unused_ok = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:16], s_axi_wstrb[3:2],
                       s_axi_awaddr[1:0], s_axi_araddr[1:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Effective swing code. Without the override, bit 14 comes from lane mode. (RL2)
  always_comb begin
    swing_eff = {swing_b15_q, swing_b14_q, swing_b13_q, swing_b12_q}; // RL1
    if (!tx_swing_override_q) begin
      swing_eff[serdes_tx_pkg::SWING_AUTO_BIT - serdes_tx_pkg::SWING_LO] = lane_is_fiber; // RL2
    end
  end

  // Read images; reserved bits of control two always read zero.
  always_comb begin
    analog_rd = 16'h0000;
    analog_rd[serdes_tx_pkg::SWING_HI:serdes_tx_pkg::SWING_LO] = swing_eff; // RL3
    analog_rd[serdes_tx_pkg::ANA_RSVD_HI:serdes_tx_pkg::ANA_RSVD_LO] = serdes_tx_pkg::ANA_RSVD_VAL;
    analog_rd[serdes_tx_pkg::PREEMPH_HI:serdes_tx_pkg::PREEMPH_LO] = preemph_q;
    analog_rd[serdes_tx_pkg::ANA_LOW_HI:0] = ana_low_q;
    ctrl2_rd = 16'h0000;
    ctrl2_rd[serdes_tx_pkg::IDLE_TEST_BIT] = idle_test_q;
    ctrl2_rd[serdes_tx_pkg::SEND_FORCE_BIT] = send_force_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel. Address and data are taken together in one cycle,
  // which keeps the decode simple at the price of one waiting channel.
  assign wr_fire = ce && s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign wr_idx = s_axi_awaddr[serdes_tx_pkg::ADDR_W-1:serdes_tx_pkg::BYTE_SHIFT];
  assign rd_idx = s_axi_araddr[serdes_tx_pkg::ADDR_W-1:serdes_tx_pkg::BYTE_SHIFT];
  assign wr_lo = wr_fire && s_axi_wstrb[0];
  assign wr_hi = wr_fire && s_axi_wstrb[1];

  // Register select by index.
  always_comb begin
    wr_is_analog = 1'b0;
    wr_is_ctrl2 = 1'b0;
    wr_is_ovr = 1'b0;
    wr_is_patch = 1'b0;
    if (wr_idx == 10'(serdes_tx_pkg::IDX_TX_ANALOG_SETTINGS)) begin
      wr_is_analog = 1'b1;
    end else if (wr_idx == 10'(serdes_tx_pkg::IDX_LANE_CONTROL_TWO)) begin
      wr_is_ctrl2 = 1'b1;
    end else if (wr_idx == 10'(serdes_tx_pkg::IDX_SWING_OVR_CTRL)) begin
      wr_is_ovr = 1'b1;
    end else if (wr_idx == 10'(serdes_tx_pkg::IDX_IDLE_STAGE_PATCH)) begin
      wr_is_patch = 1'b1;
    end
  end

  // Handshake flops: ready pulses for one cycle, response holds until taken.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= serdes_tx_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= wr_fire;
      s_axi_wready <= wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_is_analog || wr_is_ctrl2 || wr_is_ovr || wr_is_patch) ?
                       serdes_tx_pkg::RESP_OKAY : serdes_tx_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog transmit settings. Bit 14 of the swing field is not writable. (RL3)
  always_ff @(posedge clk) begin
    if (!nrst) begin
      swing_b15_q <= serdes_tx_pkg::SWING_RST[3];
      swing_b14_q <= serdes_tx_pkg::SWING_RST[2];
      swing_b13_q <= serdes_tx_pkg::SWING_RST[1];
      swing_b12_q <= serdes_tx_pkg::SWING_RST[0];
      preemph_q <= PREEMPH_W'(serdes_tx_pkg::PREEMPH_RST);
      ana_low_q <= serdes_tx_pkg::ANA_LOW_RST;
    end else if (ce && wr_is_analog) begin
      if (wr_hi) begin
        swing_b15_q <= s_axi_wdata[15]; // RL3
        swing_b13_q <= s_axi_wdata[13]; // RL3
        swing_b12_q <= s_axi_wdata[12]; // RL3
        preemph_q[PREEMPH_W-1:2] <= s_axi_wdata[serdes_tx_pkg::PREEMPH_HI:serdes_tx_pkg::PREEMPH_HI]; // RL4
      end
      if (wr_lo) begin
        preemph_q[1:0] <= s_axi_wdata[7:serdes_tx_pkg::PREEMPH_LO]; // RL4
        ana_low_q <= s_axi_wdata[serdes_tx_pkg::ANA_LOW_HI:0];
      end
    end
  end

  // Override control bit 12 of the own control register.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_swing_override_q <= 1'b0;
    end else if (ce && wr_is_ovr && wr_hi) begin
      tx_swing_override_q <= s_axi_wdata[serdes_tx_pkg::SWING_OVR_BIT]; // RL11
    end
  end

  // Control two: only bits 14, 13 and 5 exist; reserved writes are dropped.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      idle_test_q <= 1'b0;
      send_force_q <= 1'b0;
    end else if (ce && wr_is_ctrl2) begin
      if (wr_hi) begin
        idle_test_q <= s_axi_wdata[serdes_tx_pkg::IDLE_TEST_BIT]; // RL6
      end
      if (wr_lo) begin
        send_force_q <= s_axi_wdata[serdes_tx_pkg::SEND_FORCE_BIT]; // RL9
      end
    end
  end

  // Stage 6 replacement code and its enable.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      patch_en_q <= 1'b0;
      patch_code_q <= serdes_tx_pkg::PATCH_RST;
    end else if (ce && wr_is_patch) begin
      if (wr_hi) begin
        patch_en_q <= s_axi_wdata[serdes_tx_pkg::PATCH_EN_BIT]; // RL8
        patch_code_q[9:8] <= s_axi_wdata[serdes_tx_pkg::PATCH_HI:8]; // RL7
      end
      if (wr_lo) begin
        patch_code_q[7:0] <= s_axi_wdata[7:0]; // RL7
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error counter wipe. The stored bit never holds, so it reads back as zero
  // and the counter sees exactly one pulse per write of one. (RL5)
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bit_error_count_wipe <= 1'b0;
    end else if (ce) begin
      bit_error_count_wipe <= wr_is_ctrl2 && wr_hi && s_axi_wdata[serdes_tx_pkg::WIPE_BIT]; // RL5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel. One read at a time; data registered with rvalid.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= serdes_tx_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= serdes_tx_pkg::RESP_OKAY;
        if (rd_idx == 10'(serdes_tx_pkg::IDX_TX_ANALOG_SETTINGS)) begin
          s_axi_rdata <= {16'h0000, analog_rd};
        end else if (rd_idx == 10'(serdes_tx_pkg::IDX_LANE_CONTROL_TWO)) begin
          s_axi_rdata <= {16'h0000, ctrl2_rd}; // RL10
        end else if (rd_idx == 10'(serdes_tx_pkg::IDX_SWING_OVR_CTRL)) begin
          s_axi_rdata <= {19'h0, tx_swing_override_q, 12'h000};
        end else if (rd_idx == 10'(serdes_tx_pkg::IDX_IDLE_STAGE_PATCH)) begin
          s_axi_rdata <= {16'h0000, patch_en_q, 5'h00, patch_code_q};
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= serdes_tx_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Idle test sequencer. A new set is seen through the previous bit value, so
  // the first code after a set is always stage zero. (RL12)
  always_ff @(posedge clk) begin
    if (!nrst) begin
      idle_test_prev_q <= 1'b0;
      stage_q <= 4'h0;
    end else if (ce) begin
      idle_test_prev_q <= idle_test_q;
      if (idle_test_q && !idle_test_prev_q) begin
        stage_q <= 4'h1; // RL12
      end else if (idle_test_q) begin
        stage_q <= stage_q + 4'h1; // RL12
      end else begin
        stage_q <= 4'h0;
      end
    end
  end

  // Code output: table entry, with stage 6 replaced when the patch is on.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      idle_test_active <= 1'b0;
      idle_test_code <= 10'h000;
    end else if (ce) begin
      idle_test_active <= idle_test_q; // RL6
      if (!idle_test_q) begin
        idle_test_code <= 10'h000;
      end else if (patch_en_q && ((idle_test_prev_q ? stage_q : 4'h0) == 4'(serdes_tx_pkg::PATCH_STAGE))) begin
        idle_test_code <= patch_code_q; // RL7
      end else begin
        idle_test_code <= serdes_tx_pkg::IDLE_TABLE[(idle_test_prev_q ? stage_q : 4'h0) *
                          serdes_tx_pkg::CODE_W +: serdes_tx_pkg::CODE_W]; // RL6
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog and link-side outputs, all registered.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_swing_level <= SWING_W'(serdes_tx_pkg::SWING_RST);
      tx_preemph_coeff <= PREEMPH_W'(serdes_tx_pkg::PREEMPH_RST);
      send_despite_no_link <= 1'b0;
    end else if (ce) begin
      tx_swing_level <= SWING_W'(swing_eff); // RL1
      tx_preemph_coeff <= preemph_q; // RL4
      send_despite_no_link <= send_force_q; // RL9
    end
  end

endmodule
`default_nettype wire

// file: sim/serdes_tx_regs_monitor.sv
// Checker that watches the lane transmit register bank from its ports.
`timescale 1ns/10ps
`default_nettype none
module serdes_tx_regs_monitor #(
  parameter int SWING_W = 4,
  parameter int PREEMPH_W = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic [SWING_W-1:0] tx_swing_level,
  input wire logic [PREEMPH_W-1:0] tx_preemph_coeff,
  input wire logic bit_error_count_wipe,
  input wire logic send_despite_no_link,
  input wire logic idle_test_active,
  input wire logic [9:0] idle_test_code
);
  logic take_w;
  logic [3:0] stg_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  // A write is taken only when both halves meet and no answer is pending.
  assign take_w = s_axi_awvalid && s_axi_wvalid && ce && !s_axi_awready && !s_axi_bvalid;
  sequence ctl2_wr;
    take_w && s_axi_awaddr == 12'h088;
  endsequence
  sequence ana_wr;
    take_w && s_axi_awaddr == 12'h080 && s_axi_wstrb[1:0] == 2'h3;
  endsequence

  // Stage counter restarts whenever the test pattern is not running.
  always_ff @(posedge clk) begin
    if (!nrst || !idle_test_active) begin
      stg_q <= 4'h0;
    end else if (ce) begin
      stg_q <= stg_q + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_SWING_RST: assert property ($rose(nrst) |-> tx_swing_level == 4'hC)
    else $error("swing level not at reset value");
  AST_PREEMPH_RST: assert property ($rose(nrst) |-> tx_preemph_coeff == 3'h0)
    else $error("pre-emphasis not zero after reset");
  AST_PREEMPH_WR: assert property (ana_wr |=> ##1 tx_preemph_coeff == $past(s_axi_wdata[8:6], 2))
    else $error("pre-emphasis does not follow write");
  AST_WIPE_SET: assert property (ctl2_wr ##0 s_axi_wstrb[1] && s_axi_wdata[14] |=> bit_error_count_wipe)
    else $error("error count wipe missing");
  AST_WIPE_SC: assert property (bit_error_count_wipe |=> !bit_error_count_wipe)
    else $error("error count wipe longer than one cycle");
  AST_FORCE_SEND: assert property (ctl2_wr ##0 s_axi_wstrb[0] |=> ##1 send_despite_no_link == $past(s_axi_wdata[5], 2))
    else $error("forced send does not follow write");
  AST_IDLE_EN: assert property (ctl2_wr ##0 s_axi_wstrb[1] |=> ##1 idle_test_active == $past(s_axi_wdata[13], 2))
    else $error("idle test enable does not follow write");
  AST_IDLE_OFF: assert property (!idle_test_active |-> idle_test_code == 10'h000)
    else $error("idle code present while inactive");
  AST_IDLE_SEQ: assert property (idle_test_active && stg_q != 4'h6 |-> idle_test_code == serdes_tx_pkg::IDLE_TABLE[stg_q*10 +: 10])
    else $error("idle code out of order");
endmodule
bind serdes_tx_regs serdes_tx_regs_monitor #(.SWING_W(SWING_W), .PREEMPH_W(PREEMPH_W)) mon (
  .clk, .nrst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_bvalid, .tx_swing_level, .tx_preemph_coeff, .bit_error_count_wipe, .send_despite_no_link,
  .idle_test_active, .idle_test_code
);
`default_nettype wire

// file: sim/tb_serdes_tx_regs.sv
// Self-checking bench for the lane transmit register bank.
`timescale 1ns/10ps
`default_nettype none
module tb_serdes_tx_regs;
  localparam logic [1:0] OK = serdes_tx_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = serdes_tx_pkg::RESP_SLVERR;
  logic clk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic nrst = 1'b0, ce = 1'b1, lane_is_fiber = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h3, tx_swing_level;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] tx_preemph_coeff;
  logic bit_error_count_wipe, send_despite_no_link, idle_test_active;
  logic [9:0] idle_test_code;
  int fails, n_checks, wipes;

  serdes_tx_regs dut (.clk, .nrst, .ce, .lane_is_fiber, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tx_swing_level, .tx_preemph_coeff, .bit_error_count_wipe,
    .send_despite_no_link, .idle_test_active, .idle_test_code);

  ////////////////////////////////////////////////////////////////////////////
  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Wipe pulses are too short to catch from the bus tasks, so count them here.
  always @(posedge clk) begin
    if (bit_error_count_wipe === 1'b1) wipes++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus master: each valid drops on the edge its ready is seen.
  task automatic axi_wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Only bvalid or the watchdog ends this wait, so a missing answer cannot pass silently.
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk(32'(s_axi_bresp), 32'(er));
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, then swing bit 14 tracking lane mode with override clear.
  task automatic t_reset_swing();
    @(negedge clk);
    chk(32'(tx_swing_level), 32'hC);
    axi_rd(12'h080, 32'h8820, OK);
    chk(32'(tx_preemph_coeff), 32'h0);
    axi_rd(12'h088, 32'h0, OK);
    lane_is_fiber <= 1'b1;
    repeat (2) @(negedge clk);
    chk(32'(tx_swing_level), 32'hC);
    // Clock enable low must freeze the swing output although the lane mode moves.
    @(posedge clk);
    ce <= 1'b0;
    lane_is_fiber <= 1'b0;
    repeat (2) @(negedge clk);
    chk(32'(tx_swing_level), 32'hC);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(negedge clk);
    chk(32'(tx_swing_level), 32'h8);
  endtask

  // Override gives software the swing field; bit 14 itself stays unwritable.
  task automatic t_override();
    axi_wr(12'h0C0, 16'h1000, OK);
    axi_wr(12'h080, 16'h31E5, OK);
    @(negedge clk);
    chk(32'(tx_swing_level), 32'h7);
    chk(32'(tx_preemph_coeff), 32'h7);
    axi_rd(12'h080, 32'h79E5, OK);
    lane_is_fiber <= 1'b0;
    axi_wr(12'h0C0, 16'h0000, OK);
    @(negedge clk);
    chk(32'(tx_swing_level), 32'h3);
  endtask

  // Wipe is a single pulse and reads back as zero; forced send is a level.
  task automatic t_ctl2();
    axi_wr(12'h088, 16'h4020, OK);
    @(negedge clk);
    chk(32'(send_despite_no_link), 32'h1);
    chk(32'(wipes), 32'h1);
    axi_rd(12'h088, 32'h0020, OK);
    axi_wr(12'h088, 16'h0000, OK);
    @(negedge clk);
    chk(32'(send_despite_no_link), 32'h0);
  endtask

  // Idle pattern from stage 0, wrapping, with stage 6 patched only when enabled.
  task automatic t_idle(input logic pen);
    logic [3:0] s;
    axi_wr(12'h0F0, {pen, 5'h00, 10'h155}, OK);
    axi_wr(12'h088, 16'h2000, OK);
    @(negedge clk);
    chk(32'(idle_test_active), 32'h1);
    for (int k = 0; k < 20; k++) begin
      s = 4'(k);
      chk(32'(idle_test_code), 32'((s == 4'h6 && pen) ? 10'h155 : serdes_tx_pkg::IDLE_TABLE[s*10 +: 10]));
      @(negedge clk);
    end
    axi_wr(12'h088, 16'h0000, OK);
    @(negedge clk);
    chk(32'({idle_test_active, idle_test_code}), 32'h0);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; an unmapped place must answer with an error and read zero.
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset_swing();
    t_override();
    t_ctl2();
    t_idle(1'b0);
    t_idle(1'b1);
    axi_wr(12'h100, 16'hFFFF, ERR);
    axi_rd(12'h100, 32'h0, ERR);
    tally_and_finish();
  end

  // Watchdog: the whole run needs well under a thousand cycles.
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
